/* hw/tcsp_port_ctrl.sv */
// Attach detection, power path control and protection for one Type-C source port
`timescale 1ns/1ns
`include "tcsp_consts.svh"

// How it works
// - Turn VBUS path off when its current clamp outlasts the overcurrent timeout.
// - VBUS current limit follows charge-level select and both strap values.
// - Overtemperature on either sensor opens VBUS path and enters ErrorRecovery.
// - VBUS overvoltage while path on opens it and enters ErrorRecovery.
// - Supply undervoltage while path on opens it and enters ErrorRecovery.
// - Reverse current opens VBUS path; clearing recloses it after turn-on delay.
// - VCONN overcurrent while enabled engages the VCONN clamp promptly.
// - Overtemperature latches VCONN off and enters ErrorRecovery on the same clock.
// - Supply undervoltage turns VCONN off.
// - CC overvoltage or reverse current kills VCONN and the PD transmitter.
// - Both lines open means unattached, both watched, no power.
// - Rd plus open means sink; VBUS on, no VCONN, watch Rd line.
// - Ra plus open means cable only; no power, watch both lines.
// - Ra plus Rd powers VBUS and VCONN on Ra line; watch Rd line.
// - Rd/Rd is debug accessory, Ra/Ra audio; either line detaches.
// - Advertise default current until VBUS path closes, then the current-limit level.
// - Sink and accessory disconnect only after a monitored line stays high for the full debounce.
// - The lower Ra level classifies as cable VCONN input, not sink.
// - VCONN goes to the line that orientation marks as Ra.
// - Port enable low forces ErrorRecovery.
module tcsp_port_ctrl import tcsp_pkg::*; #(
	parameter int OC_TIMEOUT_CYC = `TCSP_OC_TIMEOUT_CYC,
	parameter int CC_DEBOUNCE_CYC = `TCSP_CC_DEBOUNCE_CYC,
	parameter int ATTACH_DEBOUNCE_CYC = `TCSP_ATTACH_DEBOUNCE_CYC,
	parameter int ERR_RECOVERY_CYC = `TCSP_ERR_RECOVERY_CYC,
	parameter int TURN_ON_CYC = `TCSP_TURN_ON_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// CC comparators per line: above disconnect threshold, below Ra threshold
	input wire logic [1:0] cc_open_raw,
	input wire logic [1:0] cc_ra_raw,
	input wire logic [1:0] cc_ovp_raw,
	// Power path fault flags
	input wire logic vbus_oc_clamp_raw,
	input wire logic vconn_oc_raw,
	input wire logic [1:0] overtemp_shutdown_raw,
	input wire logic vbus_ovp_raw,
	input wire logic supply_input_5v_uv_raw,
	input wire logic reverse_current_raw,
	// System controls and straps
	input wire logic port_enable,
	input wire logic charge_level_select,
	input wire logic [2:0] strap_input_one,
	input wire logic [2:0] strap_input_two,
	// Power path and CC controls
	output logic vbus_source_path,
	output logic [1:0] vconn_source_path,
	output logic vconn_clamp_en,
	output logic [1:0] vbus_current_limit,
	output logic [1:0] cc_advertise,
	output logic pd_tx_enable,
	output logic sink_attached,
	output logic debug_accessory,
	output logic audio_accessory
);
	localparam int CW = 24;
	initial begin
		if (OC_TIMEOUT_CYC < 1 || CC_DEBOUNCE_CYC < 1 || ATTACH_DEBOUNCE_CYC < 1 ||
			ERR_RECOVERY_CYC < 1 || TURN_ON_CYC < 1 || CC_DEBOUNCE_CYC >= (1 << CW) ||
			ATTACH_DEBOUNCE_CYC >= (1 << CW) || ERR_RECOVERY_CYC >= (1 << CW) ||
			OC_TIMEOUT_CYC >= (1 << CW) || TURN_ON_CYC >= (1 << CW)) begin
			$error("tcsp_port_ctrl: count parameter out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	localparam int NS = 15;
	logic [NS-1:0] raw_in, sync1_ff, sync2_ff;
	assign raw_in = {cc_open_raw, cc_ra_raw, cc_ovp_raw, vbus_oc_clamp_raw, vconn_oc_raw,
		overtemp_shutdown_raw, vbus_ovp_raw, supply_input_5v_uv_raw, reverse_current_raw,
		port_enable, charge_level_select};
	// Two flip-flops per asynchronous input
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
		end
	end
	logic [1:0] cc_open, cc_ra;
	logic cc_ovp_any, vbus_oc, vconn_oc, otemp, vbus_ovp, uvlo, rcp, en_s, chg_s;
	assign cc_open = sync2_ff[14:13];
	assign cc_ra = sync2_ff[12:11];
	assign cc_ovp_any = |sync2_ff[10:9];
	assign vbus_oc = sync2_ff[8];
	assign vconn_oc = sync2_ff[7];
	assign otemp = |sync2_ff[6:5];
	assign vbus_ovp = sync2_ff[4];
	assign uvlo = sync2_ff[3];
	assign rcp = sync2_ff[2];
	assign en_s = sync2_ff[1];
	assign chg_s = sync2_ff[0];

	// Classify one line from its comparators
	function automatic tcsp_cc_t cc_class(input logic open_i, input logic ra_i);
		if (open_i) begin
			cc_class = TCSP_CC_OPEN;
		end else if (ra_i) begin
			cc_class = TCSP_CC_RA;
		end else begin
			cc_class = TCSP_CC_RD;
		end
	endfunction : cc_class
	tcsp_cc_t cc1, cc2;
	assign cc1 = cc_class(cc_open[0], cc_ra[0]);
	assign cc2 = cc_class(cc_open[1], cc_ra[1]);

	////////////////////////////////////////////////////////////////////////
	// Attach state machine
	tcsp_state_t state_ff, nxt_state;
	logic [CW-1:0] tmr_ff, nxt_tmr;
	logic [1:0] watch_ff, nxt_watch; // Lines monitored for detach
	logic [1:0] vconn_sel_ff, nxt_vconn_sel;
	logic want_vbus_ff, nxt_want_vbus;
	logic [1:0] pat_ff, nxt_pat; // Snapshot of which lines read Rd when attach wait starts
	logic fatal, detach, oc_trip;
	assign fatal = !en_s || otemp || (vbus_source_path && (vbus_ovp || uvlo)) || oc_trip;
	assign detach = |(watch_ff & cc_open);
	// Next attach state
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_ff;
		nxt_watch = watch_ff;
		nxt_vconn_sel = vconn_sel_ff;
		nxt_want_vbus = want_vbus_ff;
		nxt_pat = pat_ff;
		case (state_ff)
			TCSP_ST_UNATTACHED: begin
				nxt_watch = 2'h3;
				nxt_vconn_sel = 2'h0;
				nxt_want_vbus = 1'b0;
				nxt_tmr = '0;
				if (cc_open != 2'h3) begin
					nxt_state = TCSP_ST_ATTACH_WAIT;
					nxt_pat = {cc2 == TCSP_CC_RD, cc1 == TCSP_CC_RD};
				end
			end
			TCSP_ST_ATTACH_WAIT: begin
				nxt_tmr = tmr_ff + 1'b1;
				if ({cc2 == TCSP_CC_RD, cc1 == TCSP_CC_RD} != pat_ff || cc_open == 2'h3) begin
					nxt_state = TCSP_ST_UNATTACHED;
				end else if (tmr_ff >= CW'(ATTACH_DEBOUNCE_CYC - 1)) begin
					nxt_tmr = '0;
					// Equal terminations here are Rd/Rd or Ra/Ra: both open left above
					if (cc1 == cc2) begin
						nxt_state = TCSP_ST_ACCESSORY;
						nxt_watch = 2'h3;
					end else if (cc1 == TCSP_CC_RD || cc2 == TCSP_CC_RD) begin
						nxt_state = TCSP_ST_SINK;
						nxt_want_vbus = 1'b1;
						nxt_watch = {cc2 == TCSP_CC_RD, cc1 == TCSP_CC_RD};
						nxt_vconn_sel = {cc2 == TCSP_CC_RA, cc1 == TCSP_CC_RA};
					end else begin
						nxt_state = TCSP_ST_CABLE_ONLY;
						nxt_watch = 2'h3;
					end
				end
			end
			TCSP_ST_SINK, TCSP_ST_ACCESSORY: begin
				// Debounced detach on the watched lines
				nxt_tmr = detach ? tmr_ff + 1'b1 : '0;
				if (detach && tmr_ff >= CW'(CC_DEBOUNCE_CYC - 1)) begin
					nxt_state = TCSP_ST_UNATTACHED;
					nxt_want_vbus = 1'b0;
					nxt_vconn_sel = 2'h0;
				end
			end
			TCSP_ST_CABLE_ONLY: begin
				// Sink arriving on the open line, or cable leaving, restarts detection
				if ((cc1 == TCSP_CC_RD) || (cc2 == TCSP_CC_RD) || (cc_open == 2'h3)) begin
					nxt_state = TCSP_ST_UNATTACHED;
				end
			end
			TCSP_ST_ERR_RECOVERY: begin
				nxt_want_vbus = 1'b0;
				nxt_vconn_sel = 2'h0;
				nxt_tmr = tmr_ff + 1'b1;
				if (tmr_ff >= CW'(ERR_RECOVERY_CYC - 1) && !fatal) begin
					nxt_state = TCSP_ST_UNATTACHED;
					nxt_tmr = '0;
				end
			end
			default: begin
				nxt_state = TCSP_ST_UNATTACHED;
			end
		endcase
		if (fatal && state_ff != TCSP_ST_ERR_RECOVERY) begin
			nxt_state = TCSP_ST_ERR_RECOVERY;
			nxt_tmr = '0;
			nxt_want_vbus = 1'b0;
			nxt_vconn_sel = 2'h0;
		end
	end
	// Register attach state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= TCSP_ST_UNATTACHED;
			tmr_ff <= '0;
			watch_ff <= 2'h3;
			vconn_sel_ff <= 2'h0;
			want_vbus_ff <= 1'b0;
			pat_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			watch_ff <= nxt_watch;
			vconn_sel_ff <= nxt_vconn_sel;
			want_vbus_ff <= nxt_want_vbus;
			pat_ff <= nxt_pat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection timers and power path outputs
	logic [CW-1:0] oc_cnt_ff, nxt_oc_cnt, rcp_cnt_ff, nxt_rcp_cnt;
	logic rcp_block_ff, nxt_rcp_block, vconn_latch_ff, nxt_vconn_latch;
	logic vbus_ff, nxt_vbus, clamp_ff, nxt_clamp, pdtx_ff, nxt_pdtx;
	logic [1:0] vconn_ff, nxt_vconn, adv_ff, nxt_adv, lim_ff, nxt_lim;
	logic [1:0] max_lvl, min_lvl;
	assign oc_trip = vbus_ff && vbus_oc && oc_cnt_ff >= CW'(OC_TIMEOUT_CYC - 1);
	// Strap two picks the maximum level; charge select drops to minimum when enabled
	assign max_lvl = strap_input_two[0] ? `TCSP_ADV_3A0 : `TCSP_ADV_1A5;
	assign min_lvl = strap_input_two[0] ? `TCSP_ADV_1A5 : `TCSP_ADV_DEFAULT;
	// Next protection values
	always_comb begin
		nxt_oc_cnt = (vbus_ff && vbus_oc) ? oc_cnt_ff + 1'b1 : '0;
		nxt_rcp_block = rcp_block_ff;
		nxt_rcp_cnt = '0;
		if (rcp) begin
			nxt_rcp_block = 1'b1;
		end else if (rcp_block_ff) begin
			nxt_rcp_cnt = rcp_cnt_ff + 1'b1;
			if (rcp_cnt_ff >= CW'(TURN_ON_CYC - 1)) begin
				nxt_rcp_block = 1'b0;
				nxt_rcp_cnt = '0;
			end
		end
		// Latched off by overtemperature until recovery ends
		nxt_vconn_latch = vconn_latch_ff;
		if (otemp) begin
			nxt_vconn_latch = 1'b1;
		end else if (state_ff == TCSP_ST_UNATTACHED) begin
			nxt_vconn_latch = 1'b0;
		end
		nxt_vbus = nxt_want_vbus && !nxt_rcp_block && !fatal;
		nxt_vconn = (otemp || uvlo || cc_ovp_any || rcp || nxt_vconn_latch) ?
			2'h0 : nxt_vconn_sel;
		nxt_clamp = vconn_oc && (|vconn_ff);
		nxt_pdtx = !(cc_ovp_any || rcp) && (state_ff == TCSP_ST_SINK);
		nxt_lim = (strap_input_one[0] && chg_s) ? min_lvl : max_lvl;
		nxt_adv = vbus_ff ? nxt_lim : `TCSP_ADV_DEFAULT;
	end
	// Register protection state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc_cnt_ff <= '0;
			rcp_cnt_ff <= '0;
			rcp_block_ff <= 1'b0;
			vconn_latch_ff <= 1'b0;
			vbus_ff <= 1'b0;
			vconn_ff <= 2'h0;
			clamp_ff <= 1'b0;
			pdtx_ff <= 1'b0;
			adv_ff <= `TCSP_ADV_DEFAULT;
			lim_ff <= `TCSP_ADV_DEFAULT;
		end else begin
			oc_cnt_ff <= nxt_oc_cnt;
			rcp_cnt_ff <= nxt_rcp_cnt;
			rcp_block_ff <= nxt_rcp_block;
			vconn_latch_ff <= nxt_vconn_latch;
			vbus_ff <= nxt_vbus;
			vconn_ff <= nxt_vconn;
			clamp_ff <= nxt_clamp;
			pdtx_ff <= nxt_pdtx;
			adv_ff <= nxt_adv;
			lim_ff <= nxt_lim;
		end
	end
	// Outputs
	assign vbus_source_path = vbus_ff;
	assign vconn_source_path = vconn_ff;
	assign vconn_clamp_en = clamp_ff;
	assign vbus_current_limit = lim_ff;
	assign cc_advertise = adv_ff;
	assign pd_tx_enable = pdtx_ff;
	assign sink_attached = (state_ff == TCSP_ST_SINK);
	assign debug_accessory = (state_ff == TCSP_ST_ACCESSORY) && (cc1 == TCSP_CC_RD);
	assign audio_accessory = (state_ff == TCSP_ST_ACCESSORY) && (cc1 == TCSP_CC_RA);

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_overtemp;
		otemp;
	endsequence
	AST_OTEMP_VBUS_OFF: assert property (@(posedge clk) disable iff (rst)
		s_overtemp |=> !vbus_source_path && state_ff == TCSP_ST_ERR_RECOVERY)
		else $error("overtemp did not open vbus and enter recovery");
	AST_OTEMP_VCONN_OFF: assert property (@(posedge clk) disable iff (rst)
		s_overtemp |=> vconn_source_path == 2'h0)
		else $error("overtemp did not open vconn");
	AST_OVP_OFF: assert property (@(posedge clk) disable iff (rst)
		(vbus_ovp && vbus_source_path) |=> !vbus_source_path)
		else $error("vbus overvoltage did not open path");
	AST_UV_OFF: assert property (@(posedge clk) disable iff (rst)
		(uvlo && vbus_source_path) |=> !vbus_source_path ##0 state_ff == TCSP_ST_ERR_RECOVERY)
		else $error("undervoltage did not open path");
	AST_UV_VCONN: assert property (@(posedge clk) disable iff (rst)
		uvlo |=> vconn_source_path == 2'h0)
		else $error("undervoltage left vconn on");
	AST_FSD: assert property (@(posedge clk) disable iff (rst)
		(cc_ovp_any || rcp) |=> vconn_source_path == 2'h0 && !pd_tx_enable)
		else $error("cc overvoltage did not shut vconn and transmitter");
	AST_RCP_OFF: assert property (@(posedge clk) disable iff (rst)
		rcp |=> !vbus_source_path)
		else $error("reverse current left vbus on");
	AST_EN_LOW: assert property (@(posedge clk) disable iff (rst)
		!en_s |=> state_ff == TCSP_ST_ERR_RECOVERY)
		else $error("port disable did not force recovery");
	AST_ADV_DEFAULT: assert property (@(posedge clk) disable iff (rst)
		!vbus_source_path |=> cc_advertise == `TCSP_ADV_DEFAULT)
		else $error("raised advertisement before vbus closed");
	AST_CLAMP: assert property (@(posedge clk) disable iff (rst)
		(vconn_oc && vconn_source_path != 2'h0) |=> vconn_clamp_en)
		else $error("vconn clamp not engaged");
	AST_UNATT_NO_POWER: assert property (@(posedge clk) disable iff (rst)
		state_ff == TCSP_ST_UNATTACHED |-> vconn_source_path == 2'h0 ##1 !vbus_source_path)
		else $error("power applied while unattached");
endmodule : tcsp_port_ctrl

/* pkg/tcsp_consts.svh */
// Timing counts and field values for the Type-C source port control block
`ifndef TCSP_CONSTS_SVH
`define TCSP_CONSTS_SVH
// Overcurrent timeout in microseconds and in cycles at 10 MHz
`define TCSP_CLK_MHZ 10
`define TCSP_OC_TIMEOUT_US 1000
`define TCSP_OC_TIMEOUT_CYC (`TCSP_OC_TIMEOUT_US * `TCSP_CLK_MHZ)
// CC disconnect debounce in microseconds and cycles
`define TCSP_CC_DEBOUNCE_US 10000
`define TCSP_CC_DEBOUNCE_CYC (`TCSP_CC_DEBOUNCE_US * `TCSP_CLK_MHZ)
// Attach debounce in microseconds and cycles
`define TCSP_ATTACH_DEBOUNCE_US 100000
`define TCSP_ATTACH_DEBOUNCE_CYC (`TCSP_ATTACH_DEBOUNCE_US * `TCSP_CLK_MHZ)
// ErrorRecovery dwell in microseconds and cycles
`define TCSP_ERR_RECOVERY_US 25000
`define TCSP_ERR_RECOVERY_CYC (`TCSP_ERR_RECOVERY_US * `TCSP_CLK_MHZ)
// Reverse-current re-enable delay in microseconds and cycles
`define TCSP_TURN_ON_US 1000
`define TCSP_TURN_ON_CYC (`TCSP_TURN_ON_US * `TCSP_CLK_MHZ)
// Advertisement and limit codes
`define TCSP_ADV_DEFAULT 2'h0
`define TCSP_ADV_1A5 2'h1
`define TCSP_ADV_3A0 2'h2
`endif

/* pkg/tcsp_pkg.sv */
// Types for the Type-C source port control block
package tcsp_pkg;
	// Termination seen on one CC line
	typedef enum logic [1:0] {
		TCSP_CC_OPEN = 2'b00,
		TCSP_CC_RD = 2'b01,
		TCSP_CC_RA = 2'b10
	} tcsp_cc_t;
	// Attach states of the port
	typedef enum logic [2:0] {
		TCSP_ST_UNATTACHED = 3'b000,
		TCSP_ST_ATTACH_WAIT = 3'b001,
		TCSP_ST_SINK = 3'b010,
		TCSP_ST_CABLE_ONLY = 3'b011,
		TCSP_ST_ACCESSORY = 3'b100,
		TCSP_ST_ERR_RECOVERY = 3'b101
	} tcsp_state_t;
endpackage : tcsp_pkg

/* dv/tcsp_far_end.sv */
// Far-side model: sink, powered cable or accessory terminations on both CC lines
`timescale 1ns/1ns
module tcsp_far_end import tcsp_pkg::*; (
	// Clock for the floating-line pattern
	input wire logic clk,
	// Termination chosen by the bench per line
	input wire tcsp_cc_t term_one,
	input wire tcsp_cc_t term_two,
	// Comparator view of both lines
	output logic [1:0] cc_open_raw,
	output logic [1:0] cc_ra_raw
);
	logic toggle_ff = 1'b0;

	// An open line gives no Ra level, so the Ra comparator wanders every cycle
	always @(posedge clk) begin
		toggle_ff <= ~toggle_ff;
	end

	// Rd keeps the line mid level, Ra pulls it below the Ra threshold
	always_comb begin
		cc_open_raw[0] = (term_one == TCSP_CC_OPEN);
		cc_open_raw[1] = (term_two == TCSP_CC_OPEN);
		cc_ra_raw[0] = cc_open_raw[0] ? toggle_ff : (term_one == TCSP_CC_RA);
		cc_ra_raw[1] = cc_open_raw[1] ? ~toggle_ff : (term_two == TCSP_CC_RA);
	end
endmodule : tcsp_far_end

/* dv/typec_source_port_control_test.sv */
// Self-checking bench for the Type-C source port control block
`timescale 1ns/1ns
module typec_source_port_control_test import tcsp_pkg::*;;
	localparam int OC = 8;
	localparam int DEB = 8;
	localparam int ATT = 8;
	localparam int ERR = 16;
	localparam int TON = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	tcsp_cc_t term_one, term_two;
	logic [1:0] cc_open_raw, cc_ra_raw, cc_ovp_raw, ot_raw, vconn, limit, adv;
	logic vbus_oc, vconn_oc, vbus_ovp, uv, rev, port_enable, cls;
	logic [2:0] strap_one, strap_two;
	logic vbus, clamp, pd_tx, sink, dbg, aud;
	int num_errors = 0;
	int compares = 0;
	int seed = 3599;

	////////////////////////////////////////////////////////////////////////////////
	// Clock, far side and design
	always #50 clk = ~clk;

	tcsp_far_end u_tcsp_far_end (.clk(clk), .term_one(term_one), .term_two(term_two),
		.cc_open_raw(cc_open_raw), .cc_ra_raw(cc_ra_raw));

	tcsp_port_ctrl #(.OC_TIMEOUT_CYC(OC), .CC_DEBOUNCE_CYC(DEB), .ATTACH_DEBOUNCE_CYC(ATT),
		.ERR_RECOVERY_CYC(ERR), .TURN_ON_CYC(TON)) u_tcsp_port_ctrl (
		.clk(clk), .rst(rst), .cc_open_raw(cc_open_raw), .cc_ra_raw(cc_ra_raw),
		.cc_ovp_raw(cc_ovp_raw), .vbus_oc_clamp_raw(vbus_oc), .vconn_oc_raw(vconn_oc),
		.overtemp_shutdown_raw(ot_raw), .vbus_ovp_raw(vbus_ovp),
		.supply_input_5v_uv_raw(uv), .reverse_current_raw(rev), .port_enable(port_enable),
		.charge_level_select(cls), .strap_input_one(strap_one), .strap_input_two(strap_two),
		.vbus_source_path(vbus), .vconn_source_path(vconn), .vconn_clamp_en(clamp),
		.vbus_current_limit(limit), .cc_advertise(adv), .pd_tx_enable(pd_tx),
		.sink_attached(sink), .debug_accessory(dbg), .audio_accessory(aud));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// Compare one design output with the expected value
	task chk(input string what, input logic [1:0] got, input int exp);
		compares++;
		if (got !== exp[1:0]) begin
			num_errors++;
			$display("MISMATCH %s at %0t: got %h expected %h", what, $time, got, exp[1:0]);
		end
	endtask : chk

	// Wait a bounded number of cycles for the VBUS path to reach a level
	task wait_vbus(input logic lvl, input int bound);
		int i;
		i = 0;
		while (vbus !== lvl && i < bound) begin
			@(negedge clk);
			i++;
		end
		chk("vbus wait", {1'b0, vbus}, int'(lvl));
		// A wait that ran out of its bound ends the run at once
		if (vbus !== lvl) begin
			tally_and_finish();
		end
	endtask : wait_vbus

	// Present terminations (0 open, 1 Rd, 2 Ra) and let the attach debounce run
	task attach(input int t1, input int t2);
		term_one = tcsp_cc_t'(t1[1:0]);
		term_two = tcsp_cc_t'(t2[1:0]);
		cyc(ATT + 12);
	endtask : attach

	task detach;
		term_one = TCSP_CC_OPEN;
		term_two = TCSP_CC_OPEN;
		cyc(DEB + 12);
		chk("vbus off", {1'b0, vbus}, 0);
		chk("vconn off", vconn, 0);
	endtask : detach

	// Reference classification of the two terminations
	task check_class(input int t1, input int t2);
		int rd, ra, vb, vc;
		rd = (t1 == 1) + (t2 == 1);
		ra = (t1 == 2) + (t2 == 2);
		vb = (rd == 1);
		vc = (rd == 1 && ra == 1) ? ((t1 == 2) ? 1 : 2) : 0;
		chk("vbus", {1'b0, vbus}, vb);
		chk("vconn", vconn, vc);
		chk("sink", {1'b0, sink}, vb);
		chk("debug", {1'b0, dbg}, int'(rd == 2));
		chk("audio", {1'b0, aud}, int'(ra == 2));
	endtask : check_class

	function int lim_of(input logic s1, input logic s2, input logic c);
		int mx, mn;
		mx = s2 ? 2 : 1;
		mn = s2 ? 1 : 0;
		return (s1 && c) ? mn : mx;
	endfunction : lim_of

	task set_fault(input int f, input logic v);
		case (f)
			0: ot_raw[0] = v;
			1: ot_raw[1] = v;
			2: vbus_ovp = v;
			3: uv = v;
			default: port_enable = ~v;
		endcase
	endtask : set_fault

	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		term_one = TCSP_CC_OPEN;
		term_two = TCSP_CC_OPEN;
		{cc_ovp_raw, ot_raw, vbus_oc, vconn_oc, vbus_ovp, uv, rev, cls} = '0;
		port_enable = 1'b1;
		strap_one = 3'($random(seed));
		strap_two = 3'($random(seed));
		cyc(16);
		chk("reset vbus", {1'b0, vbus}, 0);
		rst = 1'b0;
		cyc(ERR + 10);
		// Every termination pair, each followed by a detach
		for (int a = 0; a < 3; a++) begin
			for (int b = 0; b < 3; b++) begin
				attach(a, b);
				check_class(a, b);
				detach();
			end
		end
		$display("Classification test done");
		// Current limit and advertisement over strap and select settings
		for (int k = 0; k < 4; k++) begin
			strap_one = {2'($random(seed)), k[0]};
			strap_two = {2'($random(seed)), k[1]};
			cls = 1'($random(seed));
			term_one = TCSP_CC_RD;
			cyc(6);
			chk("adv early", adv, 0);
			wait_vbus(1'b1, 20);
			cyc(3);
			chk("limit", limit, lim_of(strap_one[0], strap_two[0], cls));
			chk("adv", adv, lim_of(strap_one[0], strap_two[0], cls));
			cls = ~cls;
			cyc(6);
			chk("limit sel", limit, lim_of(strap_one[0], strap_two[0], cls));
			detach();
		end
		$display("Current level test done");
		// Short detach glitch is ignored, a long one is taken
		attach(1, 0);
		term_one = TCSP_CC_OPEN;
		cyc(DEB - 4);
		term_one = TCSP_CC_RD;
		cyc(6);
		chk("glitch", {1'b0, vbus}, 1);
		term_one = TCSP_CC_OPEN;
		cyc(6);
		chk("early detach", {1'b0, vbus}, 1);
		wait_vbus(1'b0, 12);
		$display("Debounce test done");
		// CC overvoltage stops the transmitter
		attach(1, 0);
		chk("pd tx", {1'b0, pd_tx}, 1);
		cc_ovp_raw = 2'b10;
		cyc(5);
		chk("pd tx ovp", {1'b0, pd_tx}, 0);
		cc_ovp_raw = 2'b00;
		detach();
		// VCONN clamp engages on overcurrent
		attach(2, 1);
		chk("clamp idle", {1'b0, clamp}, 0);
		vconn_oc = 1'b1;
		cyc(5);
		chk("clamp", {1'b0, clamp}, 1);
		vconn_oc = 1'b0;
		// Reverse current opens both paths, VBUS recloses without recovery
		rev = 1'b1;
		wait_vbus(1'b0, 6);
		chk("vconn rev", vconn, 0);
		chk("pd tx rev", {1'b0, pd_tx}, 0);
		rev = 1'b0;
		wait_vbus(1'b1, TON + 6);
		chk("sink kept", {1'b0, sink}, 1);
		detach();
		$display("Protection test done");
		attach(2, 1);
		// Each fault opens the paths and passes through ErrorRecovery
		for (int f = 0; f < 5; f++) begin
			set_fault(f, 1'b1);
			cyc(1);
			chk("sync delay", {1'b0, vbus}, 1);
			wait_vbus(1'b0, 6);
			chk("vconn fault", vconn, 0);
			set_fault(f, 1'b0);
			cyc(8);
			chk("dwell", {1'b0, vbus}, 0);
			wait_vbus(1'b1, ERR + ATT + 30);
			cyc(3);
			chk("vconn back", vconn, 1);
		end
		$display("Fault test done");
		// Overcurrent clamp only acts after its timeout
		vbus_oc = 1'b1;
		cyc(6);
		chk("oc early", {1'b0, vbus}, 1);
		wait_vbus(1'b0, OC + 4);
		vbus_oc = 1'b0;
		wait_vbus(1'b1, ERR + ATT + 30);
		$display("Overcurrent test done");
		tally_and_finish();
	end
endmodule : typec_source_port_control_test
